// file: design/smb_config_port.sv
// serial management slave port: protocol, timeouts and register access
//
// How it works
// RULE_01: chip select high lets the port answer and reach the registers.
// RULE_02: chip select low makes the port ignore every bus event; bus_idle still follows start, stop and clock-high time.
// RULE_03: host keeps chip select low while talking to other slaves.
// RULE_04: port keeps working while the equalizer sits in standby.
// RULE_05: only slave address 1010110 is answered; write address byte is AC.
// RULE_06: data stays stable while the bus clock is high, except start/stop.
// RULE_07: data falling while clock high marks a start.
// RULE_08: data rising while clock high marks a stop.
// RULE_09: bus goes idle after bus free time past stop or long clock high.
// RULE_10: both register writes and register reads are served.
// RULE_11: host write: select, start, address, register address, one data byte.
// RULE_12: write acks low after address, register address and data byte.
// RULE_13: host ends a write with stop, then drops chip select.
// RULE_14: clock low from 25 ms onward aborts the transaction.
// RULE_15: slave clock stretch per message stays under 2 ms.
// RULE_16: host runs the bus clock between 10 and 100 kHz.
// RULE_17: port is ready well inside 500 ms after power-on reset.
// RULE_18: read: write address, register address, repeated start, read address, data.
// RULE_19: host ends a read with not-acknowledge, stop, then chip select low.
// RULE_20: latched register address picks the register written or read.
`timescale 1ns/1ns
`include "smb_regs.svh"

module smb_config_port #(
	parameter int CLOCK_HIGH_PERIOD_CYC = smb_pkg::ns_to_cyc(`SMB_CLOCK_HIGH_PERIOD_MAX_NS),
	parameter int TIMEOUT_CYC = smb_pkg::ns_to_cyc(`SMB_TIMEOUT_MIN_MS * `SMB_NS_PER_MS)
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic chip_select,
	input wire logic serial_clock_line,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_oe,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_write,
	input wire logic [7:0] reg_rdata,
	output logic bus_idle,
	output logic port_busy
);

	localparam int BUS_FREE_TIME_CYC = smb_pkg::ns_to_cyc(`SMB_BUS_FREE_TIME_NS);

	// ****************************************
	// link-clock capture
	// ****************************************
	smb_link_if lnk_bus ();

	smb_bit_capture u_capture (
		.serial_clock_line(serial_clock_line),
		.resetn(resetn),
		.serial_data_in(serial_data_in),
		.lnk(lnk_bus.capture)
	);

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic scl_m_r;
	logic scl_s_r;
	logic scl_d_r;
	logic sda_m_r;
	logic sda_s_r;
	logic sda_d_r;
	logic cs_m_r;
	logic cs_s_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_m_r <= 1'h1;
			scl_s_r <= 1'h1;
			scl_d_r <= 1'h1;
			sda_m_r <= 1'h1;
			sda_s_r <= 1'h1;
			sda_d_r <= 1'h1;
		end else begin
			scl_m_r <= serial_clock_line;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= serial_data_in;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cs_m_r <= 1'h0;
			cs_s_r <= 1'h0;
		end else begin
			cs_m_r <= chip_select;
			cs_s_r <= cs_m_r;
		end
	end

	// ****************************************
	// bus events
	// ****************************************
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic timeout_ev;

	assign scl_rise = scl_s_r & ~scl_d_r;
	assign scl_fall = ~scl_s_r & scl_d_r;
	// sda moves only while scl low in a frame, so a move under high scl is framing
	assign start_ev = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r; // RULE_07 RULE_06
	assign stop_ev = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r; // RULE_08 RULE_06

	// ****************************************
	// idle detection
	// ****************************************
	logic [12:0] high_cnt_r;
	logic after_stop_r;
	logic bus_idle_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			high_cnt_r <= 13'h0000;
		end else if (!(scl_s_r && sda_s_r)) begin
			high_cnt_r <= 13'h0000;
		end else if (high_cnt_r != 13'h1FFF) begin
			high_cnt_r <= high_cnt_r + 13'h0001;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			after_stop_r <= 1'h0;
		end else if (stop_ev) begin
			after_stop_r <= 1'h1;
		end else if (start_ev) begin
			after_stop_r <= 1'h0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bus_idle_r <= `SMB_IDLE_RST;
		end else if (start_ev) begin
			bus_idle_r <= 1'h0;
		end else if (after_stop_r && high_cnt_r >= 13'(BUS_FREE_TIME_CYC)) begin
			bus_idle_r <= 1'h1; // RULE_09
		end else if (high_cnt_r >= 13'(CLOCK_HIGH_PERIOD_CYC)) begin
			bus_idle_r <= 1'h1; // RULE_09
		end
	end

	// ****************************************
	// clock-low timeout
	// ****************************************
	logic [21:0] low_cnt_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			low_cnt_r <= 22'h000000;
		end else if (scl_s_r) begin
			low_cnt_r <= 22'h000000;
		end else if (low_cnt_r != 22'h3FFFFF) begin
			low_cnt_r <= low_cnt_r + 22'h000001;
		end
	end

	// fires once, at the first cycle past the least timeout
	assign timeout_ev = (low_cnt_r == 22'(TIMEOUT_CYC)); // RULE_14

	// ****************************************
	// protocol sequencer
	// ****************************************
	smb_pkg::smb_state_t state_r;
	smb_pkg::smb_state_t after_ack_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] tx_sh_r;
	logic [7:0] reg_addr_r;
	logic [7:0] reg_wdata_r;
	logic reg_write_r;
	logic sda_oe_r;
	logic sda_out_r;
	logic byte_done;
	logic [7:0] rx_byte;

	// the capture word holds still from the eighth rise to the ninth,
	// so a sample taken on the synchronised fall is safe without a handshake
	assign byte_done = scl_fall && (bit_cnt_r == `SMB_BYTE_BITS);
	assign rx_byte = lnk_bus.shift_byte;

	// bit counter: rises since the last byte boundary
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bit_cnt_r <= 4'h0;
		end else if (start_ev || !cs_s_r) begin
			bit_cnt_r <= 4'h0;
		end else if (state_r == smb_pkg::ST_ACK && scl_fall) begin
			bit_cnt_r <= 4'h0;
		end else if (scl_rise && bit_cnt_r != 4'hF) begin
			bit_cnt_r <= bit_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= smb_pkg::ST_WAIT;
			after_ack_r <= smb_pkg::ST_WAIT;
		end else if (!cs_s_r || timeout_ev || stop_ev) begin
			state_r <= smb_pkg::ST_WAIT; // RULE_02 RULE_14
		end else if (start_ev) begin
			state_r <= smb_pkg::ST_ADDR; // RULE_01 RULE_07
		end else begin
			unique case (state_r)
				smb_pkg::ST_WAIT: begin
					state_r <= smb_pkg::ST_WAIT;
				end
				smb_pkg::ST_ADDR: begin
					if (byte_done) begin
						if (rx_byte[7:1] != `SMB_SLAVE_ADDR) begin
							state_r <= smb_pkg::ST_WAIT; // RULE_05
						end else if (rx_byte[0] == `SMB_DIR_READ) begin
							state_r <= smb_pkg::ST_ACK; // RULE_18
							after_ack_r <= smb_pkg::ST_TX;
						end else begin
							state_r <= smb_pkg::ST_ACK; // RULE_12
							after_ack_r <= smb_pkg::ST_REG;
						end
					end
				end
				smb_pkg::ST_REG: begin
					if (byte_done) begin
						state_r <= smb_pkg::ST_ACK; // RULE_12
						after_ack_r <= smb_pkg::ST_DATA;
					end
				end
				smb_pkg::ST_DATA: begin
					if (byte_done) begin
						state_r <= smb_pkg::ST_ACK; // RULE_12
						after_ack_r <= smb_pkg::ST_WAIT;
					end
				end
				smb_pkg::ST_ACK: begin
					if (scl_fall) begin
						state_r <= after_ack_r;
					end
				end
				smb_pkg::ST_TX: begin
					// host answer bit is not needed: one byte per read
					if (byte_done) begin
						state_r <= smb_pkg::ST_WAIT; // RULE_19
					end
				end
				default: begin
					state_r <= smb_pkg::ST_WAIT;
				end
			endcase
		end
	end

	// ****************************************
	// register address and write data
	// ****************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_addr_r <= `SMB_REG_ADDR_RST;
		end else if (cs_s_r && state_r == smb_pkg::ST_REG && byte_done && !stop_ev) begin
			reg_addr_r <= rx_byte; // RULE_20
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_wdata_r <= `SMB_WDATA_RST;
			reg_write_r <= 1'h0;
		end else if (cs_s_r && state_r == smb_pkg::ST_DATA && byte_done && !stop_ev) begin
			reg_wdata_r <= rx_byte; // RULE_10 RULE_11
			reg_write_r <= 1'h1; // RULE_20
		end else begin
			reg_write_r <= 1'h0;
		end
	end

	// ****************************************
	// data pin drive
	// ****************************************
	// ack and data drive changes sit on a clock fall, so data is steady while clock high;
	// the port never holds the clock low, so it adds no stretch at all
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sda_oe_r <= 1'h0;
			tx_sh_r <= `SMB_SHIFT_RST;
		end else if (!cs_s_r || timeout_ev || stop_ev || start_ev) begin
			sda_oe_r <= 1'h0; // RULE_02 RULE_14
		end else if (byte_done && state_r != smb_pkg::ST_TX && state_r != smb_pkg::ST_WAIT) begin
			// address mismatch leaves the line released
			if (state_r != smb_pkg::ST_ADDR || rx_byte[7:1] == `SMB_SLAVE_ADDR) begin
				sda_oe_r <= ~`SMB_ACK_BIT; // RULE_12 RULE_06 RULE_15
			end
		end else if (state_r == smb_pkg::ST_ACK && scl_fall) begin
			if (after_ack_r == smb_pkg::ST_TX) begin
				sda_oe_r <= ~reg_rdata[7]; // RULE_18 RULE_20
				tx_sh_r <= {reg_rdata[6:0], 1'h0};
			end else begin
				sda_oe_r <= 1'h0;
			end
		end else if (state_r == smb_pkg::ST_TX && scl_fall) begin
			if (bit_cnt_r == `SMB_BYTE_BITS) begin
				sda_oe_r <= 1'h0; // RULE_19
			end else begin
				sda_oe_r <= ~tx_sh_r[7]; // RULE_06
				tx_sh_r <= {tx_sh_r[6:0], 1'h0};
			end
		end
	end

	// open drain: only ever pulls low
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sda_out_r <= 1'h0;
		end else begin
			sda_out_r <= 1'h0;
		end
	end

	// ****************************************
	// status
	// ****************************************
	logic port_busy_r;

	// no power-state input gates any of this: standby leaves the port alive,
	// and the port is ready on the first edge after reset release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			port_busy_r <= 1'h0; // RULE_17
		end else begin
			port_busy_r <= (state_r != smb_pkg::ST_WAIT); // RULE_04
		end
	end

	assign serial_data_out = sda_out_r;
	assign serial_data_oe = sda_oe_r;
	assign reg_addr = reg_addr_r;
	assign reg_wdata = reg_wdata_r;
	assign reg_write = reg_write_r;
	assign bus_idle = bus_idle_r;
	assign port_busy = port_busy_r;

endmodule : smb_config_port

// file: design/smb_regs.svh
// constants of the serial management slave port
`ifndef SMB_REGS_SVH
`define SMB_REGS_SVH

// ****************************************
// bus addressing
// ****************************************
`define SMB_SLAVE_ADDR 7'h56
`define SMB_DIR_READ 1'h1
`define SMB_ACK_BIT 1'h0
`define SMB_BYTE_BITS 4'h8

// ****************************************
// reset values
// ****************************************
`define SMB_REG_ADDR_RST 8'h00
`define SMB_WDATA_RST 8'h00
`define SMB_IDLE_RST 1'h0
`define SMB_SHIFT_RST 8'h00

// ****************************************
// timing
// ****************************************
`define SMB_CLK_PERIOD_NS 10
`define SMB_NS_PER_MS 1000000
`define SMB_BUS_FREE_TIME_NS 4700
`define SMB_CLOCK_HIGH_PERIOD_MAX_NS 50000
`define SMB_TIMEOUT_MIN_MS 25
`define SMB_TIMEOUT_MAX_MS 35
`define SMB_SEXT_MAX_MS 2
`define SMB_TPOR_MAX_MS 500

`endif

// file: design/smb_pkg.sv
// types and helpers of the serial management slave port
`include "smb_regs.svh"

package smb_pkg;

	// ****************************************
	// protocol states
	// ****************************************
	typedef enum logic [2:0] {
		ST_WAIT = 3'h0,
		ST_ADDR = 3'h1,
		ST_REG = 3'h2,
		ST_DATA = 3'h3,
		ST_ACK = 3'h4,
		ST_TX = 3'h5
	} smb_state_t;

	// least time in ns to whole clock cycles, never below one
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + `SMB_CLK_PERIOD_NS - 1) / `SMB_CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc

endpackage : smb_pkg

// file: design/smb_link_if.sv
// byte path from the serial-clock capture to the protocol logic
`timescale 1ns/1ns

interface smb_link_if;
	logic [7:0] shift_byte;

	modport capture (
		output shift_byte
	);

	modport ctrl (
		input shift_byte
	);
endinterface : smb_link_if

// file: design/smb_bit_capture.sv
// data capture clocked by the bus clock pin
`timescale 1ns/1ns
`include "smb_regs.svh"

module smb_bit_capture (
	input wire logic serial_clock_line,
	input wire logic resetn,
	input wire logic serial_data_in,
	smb_link_if.capture lnk
);

	logic [7:0] shift_r;

	// ****************************************
	// shift on every rising bus clock
	// ****************************************
	// no frame reset here: the protocol side knows where bytes start
	always_ff @(posedge serial_clock_line or negedge resetn) begin
		if (!resetn) begin
			shift_r <= `SMB_SHIFT_RST;
		end else begin
			shift_r <= {shift_r[6:0], serial_data_in};
		end
	end

	assign lnk.shift_byte = shift_r;

endmodule : smb_bit_capture

// file: tb/smb_config_port_monitor.sv
// port checks for the serial management slave port
`timescale 1ns/1ns
module smb_config_port_monitor #(
	parameter int CLOCK_HIGH_PERIOD_CYC = 5000,
	parameter int TIMEOUT_CYC = 2500000
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic chip_select,
	input wire logic serial_clock_line,
	input wire logic serial_data_in,
	input wire logic serial_data_out,
	input wire logic serial_data_oe,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic [7:0] reg_rdata,
	input wire logic bus_idle,
	input wire logic port_busy
);
	// raw pin counts run ahead of the design's synchronised view
	localparam int BUS_FREE_TIME_CYC = 470;
	int hi_cnt;
	int lo_cnt;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hi_cnt <= 0;
			lo_cnt <= 0;
		end else begin
			hi_cnt <= (serial_clock_line && serial_data_in) ? hi_cnt + 1 : 0;
			lo_cnt <= serial_clock_line ? 0 : lo_cnt + 1;
		end
	end
	// ****************
	// assertions
	// ****************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence seq_sel; chip_select [*4]; endsequence
	sequence seq_start; serial_clock_line && $fell(serial_data_in); endsequence
	sequence seq_stop; serial_clock_line && $rose(serial_data_in); endsequence
	AST_DESEL_QUIET: assert property (!chip_select [*6] |-> !port_busy && !serial_data_oe && !reg_write)
		else $error("port active while deselected");
	AST_START_BUSY: assert property (seq_sel ##0 seq_start |-> ##[1:6] (port_busy && !bus_idle))
		else $error("start not taken");
	AST_STOP_FREE: assert property (seq_sel ##0 seq_stop |-> ##[1:6] !port_busy)
		else $error("stop not taken");
	AST_OE_STILL: assert property ((chip_select && serial_clock_line) [*3] |-> $stable(serial_data_oe))
		else $error("data drive moved while clock high");
	AST_OE_LOW: assert property ($rose(serial_data_oe) |-> !serial_clock_line && !serial_data_out)
		else $error("ack drive not low or not in clock low");
	AST_WDATA_WRITE: assert property ($changed(reg_wdata) |-> reg_write ##1 !reg_write [*8])
		else $error("write data without single pulse");
	AST_TIMEOUT: assert property (lo_cnt == TIMEOUT_CYC + 8 |-> !port_busy && !serial_data_oe)
		else $error("clock low timeout missed");
	AST_IDLE_BUS_FREE_TIME: assert property ($rose(bus_idle) |-> hi_cnt >= BUS_FREE_TIME_CYC)
		else $error("idle too early");
	AST_IDLE_CLOCK_HIGH_PERIOD: assert property (hi_cnt == CLOCK_HIGH_PERIOD_CYC + 4 && chip_select |-> bus_idle)
		else $error("idle missing after long high");
endmodule : smb_config_port_monitor

// file: tb/smb_host_model.sv
// bus host driving clock, data and chip select
`timescale 1ns/1ns
module smb_host_model (
	output logic scl,
	output logic sda_low,
	output logic cs,
	input wire logic sda
);
	// quarter bit; far faster than a real bus, to keep the run short
	// bus periods and timeouts are scaled down together for the bench
	localparam int Q = 120;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		cs = 1'b0;
	end
	task automatic sel(input logic on);
		cs = on;
		#100;
	endtask : sel
	task automatic start();
		if (!scl) begin
			#Q sda_low = 1'b0;
			#Q scl = 1'b1;
			#(2 * Q);
		end
		sda_low = 1'b1;
		#(2 * Q) scl = 1'b0;
	endtask : start
	task automatic stop();
		#Q sda_low = 1'b1;
		#Q scl = 1'b1;
		#(2 * Q) sda_low = 1'b0;
		#(2 * Q);
	endtask : stop
	task automatic put_byte(input logic [7:0] v, output logic [7:0] rd, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			#Q sda_low = (i > 0) ? !v[i - 1] : 1'b0;
			#Q scl = 1'b1;
			#Q if (i > 0) rd[i - 1] = sda;
			ack = sda;
			#Q scl = 1'b0;
		end
	endtask : put_byte
endmodule : smb_host_model

// file: tb/tb_smb_config_port.sv
// self-checking bench for the serial management slave port
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_smb_config_port;
	localparam int CLOCK_HIGH_PERIOD = 600;
	localparam int TMO = 2000;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic chip_select, scl, sda_low, serial_data_out, serial_data_oe, reg_write, bus_idle, port_busy;
	logic [7:0] reg_addr, reg_wdata, rd;
	logic [7:0] reg_rdata = 8'h00;
	wire logic sda;
	logic a0, a1, a2, a3;
	int bad_count = 0;
	int comparisons = 0;
	int wr_cnt = 0;
	always #5 clk = ~clk;
	// open-drain data wire with pull-up
	assign sda = !(sda_low || (serial_data_oe && !serial_data_out));
	always @(posedge clk) reg_rdata <= #1 ~reg_addr;
	always @(negedge clk) if (reg_write) wr_cnt++;
	smb_host_model smb_host_model_inst (.scl(scl), .sda_low(sda_low), .cs(chip_select), .sda(sda));
	smb_config_port #(.CLOCK_HIGH_PERIOD_CYC(CLOCK_HIGH_PERIOD), .TIMEOUT_CYC(TMO)) smb_config_port_inst (
		.clk(clk), .resetn(resetn), .chip_select(chip_select), .serial_clock_line(scl),
		.serial_data_in(sda), .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata),
		.bus_idle(bus_idle), .port_busy(port_busy));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic xb(input logic [7:0] v, output logic ack);
		smb_host_model_inst.put_byte(v, rd, ack);
	endtask : xb
	// one transaction: select, start, bytes (0 to 3 after the first), stop, deselect
	task automatic txn(input logic s, input logic [7:0] b0, b1, b2, b3, input int n);
		smb_host_model_inst.sel(s);
		smb_host_model_inst.start();
		xb(b0, a0);
		if (n > 0) xb(b1, a1);
		if (n > 1) xb(b2, a2);
		if (n > 2) xb(b3, a3);
		smb_host_model_inst.stop();
		smb_host_model_inst.sel(1'b0);
	endtask : txn
	task automatic t_write(input logic [7:0] ra, input logic [7:0] wd);
		int n0 = wr_cnt;
		txn(1'b1, 8'hAC, ra, wd, 8'h5A, 3);
		`CHK("write acks", 4'b0001, {a0, a1, a2, a3})
		`CHK("reg_addr", ra, reg_addr)
		`CHK("reg_wdata", wd, reg_wdata)
		`CHK("writes", 1, wr_cnt - n0)
	endtask : t_write
	task automatic t_read(input logic [7:0] ra);
		int n0 = wr_cnt;
		smb_host_model_inst.sel(1'b1);
		smb_host_model_inst.start();
		xb(8'hAC, a2);
		xb(ra, a3);
		txn(1'b1, 8'hAD, 8'hFF, 8'h00, 8'h00, 1);
		`CHK("read acks", 4'b0001, {a2, a3, a0, a1})
		`CHK("read data", ~ra, rd)
		`CHK("read addr", ra, reg_addr)
		`CHK("read no write", 0, wr_cnt - n0)
	endtask : t_read
	task automatic t_refused();
		logic [7:0] ads [4] = '{8'hAE, 8'h2C, 8'hEC, 8'hAC};
		logic [7:0] ra0 = reg_addr;
		int n0 = wr_cnt;
		foreach (ads[i]) begin
			txn(i < 3, ads[i], 8'h09, 8'h99, 8'h00, 2);
			`CHK("refused acks", 3'b111, {a0, a1, a2})
		end
		`CHK("refused addr", ra0, reg_addr)
		`CHK("refused writes", 0, wr_cnt - n0)
	endtask : t_refused
	task automatic t_timeout();
		smb_host_model_inst.sel(1'b1);
		smb_host_model_inst.start();
		xb(8'hAC, a2);
		cyc(TMO + 50);
		`CHK("abort busy", 1'b0, port_busy)
		txn(1'b1, 8'h33, 8'h00, 8'h00, 8'h00, 0);
		`CHK("timeout acks", 2'b01, {a2, a0})
	endtask : t_timeout
	task automatic t_idle();
		smb_host_model_inst.sel(1'b1);
		cyc(CLOCK_HIGH_PERIOD + 20);
		`CHK("idle long high", 1'b1, bus_idle)
		smb_host_model_inst.start();
		cyc(8);
		`CHK("start", 2'b10, {port_busy, bus_idle})
		xb(8'hAC, a0);
		smb_host_model_inst.stop();
		`CHK("stop", 1'b0, port_busy)
		cyc(400);
		`CHK("before free time", 1'b0, bus_idle)
		cyc(90);
		`CHK("after free time", 1'b1, bus_idle)
		smb_host_model_inst.sel(1'b0);
	endtask : t_idle
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (2) @(posedge clk);
		#1 resetn = 1'b1;
		`CHK("reset state", 19'h0, {serial_data_oe, reg_addr, reg_wdata, bus_idle, reg_write})
		// no stop seen yet, so only the long clock-high path can raise idle
		cyc(500);
		`CHK("idle before long high", 1'b0, bus_idle)
		cyc(120);
		`CHK("idle after long high", 1'b1, bus_idle)
		t_write(8'h00, 8'hFF);
		t_write(8'hFF, 8'h00);
		t_read(8'h03);
		t_read(8'h80);
		t_refused();
		t_timeout();
		t_write(8'h07, 8'h01);
		t_idle();
		complete_run();
	end
	initial begin
		#500000;
		bad_count++;
		complete_run();
	end
endmodule : tb_smb_config_port
bind smb_config_port smb_config_port_monitor #(.CLOCK_HIGH_PERIOD_CYC(CLOCK_HIGH_PERIOD_CYC), .TIMEOUT_CYC(TIMEOUT_CYC))
	smb_config_port_monitor_inst (.clk(clk), .resetn(resetn), .chip_select(chip_select),
	.serial_clock_line(serial_clock_line), .serial_data_in(serial_data_in),
	.serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata), .bus_idle(bus_idle),
	.port_busy(port_busy));
